/* File: core/pae_pkg.sv */
package pae_pkg;
  // ********************************
  // sizes
  // ********************************
  localparam int CH_N = 4;
  localparam int DW = 16;
  localparam int EW = 18;
  localparam int KIND_W = 5;
  localparam int AW = 8;
  localparam int IRQ_W = 5;
  localparam int IRQ_REJECT = 4;
  localparam int ASSIGN_BIT = 8;
  localparam int CTRL_RESTART_BIT = 0;
  localparam int SLOT_MSB = 7;
  localparam int SLOT_LSB = 5;

  // ********************************
  // type codes
  // ********************************
  localparam logic [KIND_W-1:0] TYPE_OFF = 5'h00;
  localparam logic [KIND_W-1:0] TYPE_BAND_OUT = 5'h01;
  localparam logic [KIND_W-1:0] TYPE_UPPER = 5'h02;
  localparam logic [KIND_W-1:0] TYPE_LOWER = 5'h03;
  localparam logic [KIND_W-1:0] TYPE_BAND_IN = 5'h04;
  localparam logic [KIND_W-1:0] TYPE_BAND_OUT_SB = 5'h05;
  localparam logic [KIND_W-1:0] TYPE_UPPER_SB = 5'h06;
  localparam logic [KIND_W-1:0] TYPE_LOWER_SB = 5'h07;
  localparam logic [KIND_W-1:0] TYPE_ABS_UPPER = 5'h08;
  localparam logic [KIND_W-1:0] TYPE_LOOP = 5'h0C;
  localparam logic [KIND_W-1:0] TYPE_RATE = 5'h0D;
  localparam logic [KIND_W-1:0] TYPE_RST = TYPE_UPPER;
  localparam logic [DW-1:0] HYST_RST = 16'h0002;

  // ********************************
  // register map
  // ********************************
  localparam logic [AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AW-1:0] REG_LIVE = 8'h04;
  localparam logic [AW-1:0] REG_IRQ_STAT = 8'h08;
  localparam logic [AW-1:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [2:0] SLOT_FIRST = 3'h1;
  localparam logic [2:0] SLOT_LAST = 3'h4;
  localparam logic [4:0] CH_TYPE = 5'h00;
  localparam logic [4:0] CH_VALUE = 5'h04;
  localparam logic [4:0] CH_UPPER = 5'h08;
  localparam logic [4:0] CH_LOWER = 5'h0C;
  localparam logic [4:0] CH_HYST = 5'h10;

  typedef enum {
    MODE_OFF, MODE_BAND_OUT, MODE_UPPER, MODE_LOWER, MODE_BAND_IN, MODE_ABS_UP, MODE_LOOP
  } pae_mode_t;

  typedef struct packed {
    logic [KIND_W-1:0] kind;
    logic assigned;
    logic signed [DW-1:0] value;
    logic signed [DW-1:0] upper;
    logic signed [DW-1:0] lower;
    logic signed [DW-1:0] hyst;
  } pae_cfg_t;

  typedef struct packed {
    logic signed [DW-1:0] pv;
    logic signed [DW-1:0] sp;
  } pae_meas_t;
endpackage

/* File: core/pae_channel.sv */
`timescale 1ns/1ns
module pae_channel (
  input wire logic clk_sys,
  input wire logic reset,
  input wire pae_pkg::pae_cfg_t cfg,
  input wire pae_pkg::pae_meas_t meas,
  input wire logic restart,
  input wire logic lba_in,
  output logic alarm
);
  import pae_pkg::*;

  pae_mode_t mode;
  logic stby, armed, trip, hold, overlap, next_alarm;
  logic signed [EW-1:0] pv, h, hi_lim, lo_lim, up_thr, dn_thr, abs_thr;

  // ********************************
  // thresholds
  // ********************************
  // widened so sp plus deviation cannot wrap
  assign pv = EW'(meas.pv);
  assign h = (cfg.kind == TYPE_LOOP || cfg.kind == TYPE_RATE) ? '0 : EW'(cfg.hyst);
  assign hi_lim = EW'(meas.sp) + EW'(cfg.upper);
  assign lo_lim = EW'(meas.sp) - EW'(cfg.lower);
  assign up_thr = EW'(meas.sp) + EW'(cfg.value);
  assign dn_thr = EW'(meas.sp) - EW'(cfg.value);
  assign abs_thr = EW'(cfg.value);
  assign overlap = (hi_lim - h) <= (lo_lim + h);
  assign stby = (cfg.kind == TYPE_BAND_OUT_SB) || (cfg.kind == TYPE_UPPER_SB) ||
                (cfg.kind == TYPE_LOWER_SB);

  always_comb begin
    case (cfg.kind)
      TYPE_BAND_OUT, TYPE_BAND_OUT_SB: mode = MODE_BAND_OUT;
      TYPE_UPPER, TYPE_UPPER_SB: mode = MODE_UPPER;
      TYPE_LOWER, TYPE_LOWER_SB: mode = MODE_LOWER;
      TYPE_BAND_IN: mode = MODE_BAND_IN;
      TYPE_ABS_UPPER: mode = MODE_ABS_UP;
      TYPE_LOOP: mode = MODE_LOOP;
      default: mode = MODE_OFF;
    endcase
  end

  // ********************************
  // evaluation
  // ********************************
  always_comb begin
    trip = 1'b0;
    hold = 1'b0;
    case (mode)
      MODE_BAND_OUT: begin
        trip = (pv > hi_lim) || (pv < lo_lim);
        hold = (pv > hi_lim - h) || (pv < lo_lim + h);
      end
      MODE_UPPER: begin
        trip = pv >= up_thr;
        hold = pv >= up_thr - h;
      end
      MODE_LOWER: begin
        trip = pv <= dn_thr;
        hold = pv <= dn_thr + h;
      end
      MODE_BAND_IN: begin
        trip = (pv >= lo_lim) && (pv <= hi_lim);
        hold = (pv >= lo_lim - h) && (pv <= hi_lim + h);
      end
      MODE_ABS_UP: begin
        trip = pv > abs_thr;
        hold = pv > abs_thr - h;
      end
      default: begin
        trip = 1'b0;
        hold = 1'b0;
      end
    endcase
  end

  always_comb begin
    if (!cfg.assigned || mode == MODE_OFF) begin
      next_alarm = 1'b0;
    end else if (mode == MODE_LOOP) begin
      next_alarm = lba_in;
    end else if (stby && (armed || restart)) begin
      next_alarm = 1'b0;
    end else if (cfg.kind == TYPE_BAND_OUT_SB && overlap) begin
      next_alarm = 1'b0;
    end else begin
      next_alarm = alarm ? hold : trip;
    end
  end

  // restart wins over the disarm in the same cycle
  always_ff @(posedge clk_sys) begin
    if (reset || restart || !cfg.assigned) begin
      armed <= 1'b1;
    end else if (stby && armed && !trip) begin
      armed <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      alarm <= 1'b0;
    end else begin
      alarm <= next_alarm;
    end
  end

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  chk_off_disabled: assert property ((cfg.kind == TYPE_OFF) |=> !alarm)
    else $error("type zero drove the alarm");
  chk_unassigned_off: assert property (!cfg.assigned |=> !alarm)
    else $error("unassigned channel alarmed");
  chk_band_outside: assert property ((cfg.assigned && cfg.kind == TYPE_BAND_OUT
    && (pv > hi_lim || pv < lo_lim)) |=> alarm) else $error("band outside missed");
  chk_upper_trip: assert property ((cfg.assigned && cfg.kind == TYPE_UPPER
    && pv >= up_thr) |=> alarm) else $error("upper deviation missed");
  chk_lower_trip: assert property ((cfg.assigned && cfg.kind == TYPE_LOWER
    && pv <= dn_thr) |=> alarm) else $error("lower deviation missed");
  chk_band_inside: assert property ((cfg.assigned && cfg.kind == TYPE_BAND_IN
    && pv >= lo_lim && pv <= hi_lim) |=> alarm) else $error("band inside missed");
  chk_upper_standby: assert property ((cfg.assigned && cfg.kind == TYPE_UPPER_SB
    && !armed && !restart && pv >= up_thr) |=> alarm) else $error("armed upper missed");
  chk_abs_trip: assert property ((cfg.assigned && cfg.kind == TYPE_ABS_UPPER
    && pv > abs_thr) |=> alarm) else $error("absolute upper missed");
  chk_overlap_off: assert property ((cfg.kind == TYPE_BAND_OUT_SB && overlap)
    |=> !alarm) else $error("overlap did not hold off");
  chk_loop_follow: assert property ((cfg.assigned && cfg.kind == TYPE_LOOP)
    |=> (alarm == $past(lba_in))) else $error("loop alarm not direct");
  chk_standby_wait: assert property ((stby && armed) |=> !alarm)
    else $error("standby did not suppress");
  chk_hyst_hold: assert property ((alarm && cfg.assigned && cfg.kind == TYPE_UPPER
    && pv >= up_thr - h) |=> alarm) else $error("released inside hysteresis");
endmodule

/* File: core/pae_top.sv */
`timescale 1ns/1ns
module pae_top #(
  parameter bit POS_PROP = 1'b0
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pae_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pae_pkg::pae_meas_t meas,
  input wire logic loop_break_alarm,
  output logic [pae_pkg::CH_N-1:0] alarm_out,
  output logic irq
);
  import pae_pkg::*;

  // ********************************
  // bus decode
  // ********************************
  logic setup_ph, acc_wr, ch_hit, mapped;
  logic [2:0] slot;
  logic [4:0] ch_off;
  logic [1:0] ch_sel;

  assign setup_ph = psel && !penable;
  assign acc_wr = psel && penable && pwrite;
  assign slot = paddr[SLOT_MSB:SLOT_LSB];
  assign ch_off = paddr[SLOT_LSB-1:0];
  assign ch_hit = (slot >= SLOT_FIRST) && (slot <= SLOT_LAST);
  assign ch_sel = 2'(slot - SLOT_FIRST);
  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;

  always_comb begin
    mapped = 1'b0;
    if (ch_hit) begin
      case (ch_off)
        CH_TYPE, CH_VALUE, CH_UPPER, CH_LOWER, CH_HYST: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end else begin
      case (paddr)
        REG_CTRL, REG_LIVE, REG_IRQ_STAT, REG_IRQ_MASK: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  end

  // ********************************
  // type code acceptance
  // ********************************
  logic [KIND_W-1:0] new_kind;
  logic kind_legal, type_wr, type_ok, reject_ev;

  assign new_kind = pwdata[KIND_W-1:0];

  // unsupported codes are refused as a whole write, assignment bit included
  always_comb begin
    if (new_kind == TYPE_LOOP) begin
      kind_legal = (ch_sel == 2'h0) && !POS_PROP;
    end else begin
      kind_legal = new_kind <= TYPE_ABS_UPPER;
    end
  end

  assign type_wr = acc_wr && ch_hit && (ch_off == CH_TYPE);
  assign type_ok = type_wr && kind_legal;
  assign reject_ev = type_wr && !kind_legal;

  // ********************************
  // channel configuration
  // ********************************
  pae_cfg_t [CH_N-1:0] cfg;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < CH_N; i++) begin
        cfg[i].kind <= TYPE_RST;
        cfg[i].assigned <= 1'b0;
        cfg[i].value <= '0;
        cfg[i].upper <= '0;
        cfg[i].lower <= '0;
        cfg[i].hyst <= HYST_RST;
      end
    end else if (acc_wr && ch_hit) begin
      case (ch_off)
        CH_TYPE: begin
          if (kind_legal) begin
            cfg[ch_sel].kind <= new_kind;
            cfg[ch_sel].assigned <= pwdata[ASSIGN_BIT];
          end
        end
        CH_VALUE: cfg[ch_sel].value <= pwdata[DW-1:0];
        CH_UPPER: cfg[ch_sel].upper <= pwdata[DW-1:0];
        CH_LOWER: cfg[ch_sel].lower <= pwdata[DW-1:0];
        CH_HYST: cfg[ch_sel].hyst <= pwdata[DW-1:0];
        default: begin
        end
      endcase
    end
  end

  // ********************************
  // standby restart
  // ********************************
  logic sb_restart;
  logic [CH_N-1:0] restart;

  assign sb_restart = acc_wr && (paddr == REG_CTRL) && pwdata[CTRL_RESTART_BIT];

  // a new type code starts its standby afresh
  always_comb begin
    for (int i = 0; i < CH_N; i++) begin
      restart[i] = sb_restart ||
                   (type_ok && (ch_sel == 2'(i)) && (new_kind != cfg[i].kind));
    end
  end

  // ********************************
  // channels
  // ********************************
  for (genvar g = 0; g < CH_N; g++) begin : g_ch
    pae_channel u_ch (
      .clk_sys(clk_sys),
      .reset(reset),
      .cfg(cfg[g]),
      .meas(meas),
      .restart(restart[g]),
      .lba_in((g == 0) ? loop_break_alarm : 1'b0),
      .alarm(alarm_out[g])
    );
  end

  // ********************************
  // interrupts
  // ********************************
  logic [CH_N-1:0] alarm_q;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      alarm_q <= '0;
    end else begin
      alarm_q <= alarm_out;
    end
  end

  assign irq_set = {reject_ev, alarm_out & ~alarm_q};
  assign irq_clr = (acc_wr && paddr == REG_IRQ_STAT) ? pwdata[IRQ_W-1:0] : '0;

  // set beats clear so an event in the clearing cycle survives
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_mask <= '0;
    end else if (acc_wr && paddr == REG_IRQ_MASK) begin
      irq_mask <= pwdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ********************************
  // read path
  // ********************************
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = '0;
    if (ch_hit) begin
      case (ch_off)
        CH_TYPE: begin
          next_rdata[KIND_W-1:0] = cfg[ch_sel].kind;
          next_rdata[ASSIGN_BIT] = cfg[ch_sel].assigned;
        end
        CH_VALUE: next_rdata[DW-1:0] = cfg[ch_sel].value;
        CH_UPPER: next_rdata[DW-1:0] = cfg[ch_sel].upper;
        CH_LOWER: next_rdata[DW-1:0] = cfg[ch_sel].lower;
        CH_HYST: next_rdata[DW-1:0] = cfg[ch_sel].hyst;
        default: next_rdata = '0;
      endcase
    end else begin
      case (paddr)
        REG_LIVE: next_rdata[CH_N-1:0] = alarm_out;
        REG_IRQ_STAT: next_rdata[IRQ_W-1:0] = irq_stat;
        REG_IRQ_MASK: next_rdata[IRQ_W-1:0] = irq_mask;
        default: next_rdata = '0;
      endcase
    end
  end

  // captured in the setup cycle, so data sits on flops for the access cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata <= pwrite ? '0 : next_rdata;
      pslverr <= !mapped;
    end
  end

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  chk_lba_reject: assert property ((type_wr && new_kind == TYPE_LOOP
    && ch_sel != 2'h0) |=> ($stable(cfg) && irq_stat[IRQ_REJECT]))
    else $error("loop break taken on a later channel");
  chk_reject_sticky: assert property ((irq_stat[IRQ_REJECT] && irq_clr[IRQ_REJECT] == 1'b0)
    |=> irq_stat[IRQ_REJECT]) else $error("reject flag dropped");
  chk_pos_prop_lba: assert property ((POS_PROP && type_wr && new_kind == TYPE_LOOP)
    |=> ($stable(cfg) && irq_stat[IRQ_REJECT]))
    else $error("loop break taken on position variant");
  chk_type_write: assert property (type_ok
    |=> (cfg[$past(ch_sel)].kind == $past(new_kind)))
    else $error("legal type code not stored");
  chk_hyst_write: assert property ((acc_wr && ch_hit && ch_off == CH_HYST)
    |=> (cfg[$past(ch_sel)].hyst == $past(pwdata[DW-1:0])))
    else $error("hysteresis write lost");
  chk_rise_flag: assert property ((alarm_out[0] && !alarm_q[0]) |=> irq_stat[0])
    else $error("alarm rise not flagged");

  cov_alarm_rise: cover property (alarm_out[0] && !alarm_q[0]);
  cov_reject: cover property (reject_ev);
  cov_irq: cover property ($rose(irq));
  cov_restart: cover property (sb_restart);
endmodule

/* File: sim/pae_meas_model.sv */
`timescale 1ns/1ns
module pae_meas_model (
  input wire logic clk_sys,
  input wire logic [15:0] pv_set,
  input wire logic [15:0] sp_set,
  input wire logic lb_set,
  output pae_pkg::pae_meas_t meas,
  output logic loop_break_alarm
);
  import pae_pkg::*;
  // ********************************
  // sampled measurement
  // ********************************
  // converter result lands one edge after the request, never mid-cycle
  always_ff @(posedge clk_sys) begin
    meas.pv <= pv_set;
    meas.sp <= sp_set;
    loop_break_alarm <= lb_set;
  end
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/1ns
module testbench;
  import pae_pkg::*;
  logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, irq;
  logic lb_set, loop_break_alarm, er;
  logic [AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] pv_set, sp_set;
  logic [CH_N-1:0] alarm_out;
  pae_meas_t meas;
  int n_mismatch, n_compared;

  pae_top dut (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .meas(meas), .loop_break_alarm(loop_break_alarm),
    .alarm_out(alarm_out), .irq(irq));
  pae_meas_model model (.clk_sys(clk_sys), .pv_set(pv_set), .sp_set(sp_set),
    .lb_set(lb_set), .meas(meas), .loop_break_alarm(loop_break_alarm));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ********************************
  // shared tasks
  // ********************************
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until pready is seen at an edge; no fixed latency assumed
  task automatic xfer(input logic wr, input logic [AW-1:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [AW-1:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic cfg(input logic [2:0] ch, input logic [4:0] ty, input logic [15:0] x,
      input logic [15:0] h, input logic [15:0] l);
    xfer(1'b1, {ch, CH_VALUE}, {16'h0000, x});
    xfer(1'b1, {ch, CH_UPPER}, {16'h0000, h});
    xfer(1'b1, {ch, CH_LOWER}, {16'h0000, l});
    xfer(1'b1, {ch, CH_TYPE}, {23'h0, 1'b1, 3'h0, ty});
  endtask

  // model adds one edge, alarm path one more; third edge is margin
  task automatic meas_to(input logic [15:0] pv, input logic [15:0] sp);
    @(posedge clk_sys);
    pv_set <= pv;
    sp_set <= sp;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  task automatic alm(input logic [3:0] exp);
    chk({28'h0, alarm_out}, {28'h0, exp});
  endtask

  // ********************************
  // sequence
  // ********************************
  initial begin
    {reset, psel, penable, pwrite, lb_set} = 5'b10000;
    paddr = '0;
    pwdata = '0;
    pv_set = '0;
    sp_set = '0;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    rdc({3'h1, CH_TYPE}, 32'h0000_0002);
    rdc({3'h1, CH_HYST}, 32'h0000_0002);
    xfer(1'b0, 8'h14, 32'h0);
    chk({31'h0, er}, 32'h1);
    meas_to(16'd100, 16'd0);
    alm(4'b0000);
    cfg(3'h1, TYPE_UPPER, 16'd10, 16'd0, 16'd0);
    meas_to(16'd40, 16'd30);
    alm(4'b0001);
    meas_to(16'd8, 16'd0);
    alm(4'b0001);
    meas_to(16'd7, 16'd0);
    alm(4'b0000);
    meas_to(16'd9, 16'd0);
    alm(4'b0000);
    cfg(3'h1, TYPE_LOWER, 16'd10, 16'd0, 16'd0);
    meas_to(-16'sd9, 16'd0);
    alm(4'b0000);
    meas_to(-16'sd10, 16'd0);
    alm(4'b0001);
    meas_to(16'd0, 16'd0);
    cfg(3'h1, TYPE_BAND_OUT, 16'd0, 16'd20, 16'd10);
    meas_to(16'd20, 16'd0);
    alm(4'b0000);
    meas_to(16'd21, 16'd0);
    alm(4'b0001);
    meas_to(16'd0, 16'd0);
    alm(4'b0000);
    meas_to(-16'sd11, 16'd0);
    alm(4'b0001);
    meas_to(16'd0, 16'd0);
    cfg(3'h1, TYPE_BAND_IN, 16'd0, 16'd20, 16'd10);
    meas_to(16'd0, 16'd0);
    alm(4'b0001);
    meas_to(16'd23, 16'd0);
    alm(4'b0000);
    meas_to(16'd21, 16'd0);
    alm(4'b0000);
    meas_to(16'd20, 16'd0);
    alm(4'b0001);
    cfg(3'h1, TYPE_ABS_UPPER, 16'd5, 16'd0, 16'd0);
    meas_to(16'd6, 16'd100);
    alm(4'b0001);
    meas_to(16'd3, -16'sd100);
    alm(4'b0000);
    meas_to(16'd6, 16'd0);
    cfg(3'h1, TYPE_OFF, 16'd5, 16'd0, 16'd0);
    meas_to(16'd6, 16'd0);
    alm(4'b0000);
    meas_to(16'd0, 16'd0);
    cfg(3'h1, TYPE_BAND_OUT_SB, 16'd0, 16'd1, 16'd1);
    meas_to(16'd50, 16'd0);
    alm(4'b0000);
    cfg(3'h1, TYPE_BAND_OUT_SB, 16'd0, 16'd20, 16'd10);
    xfer(1'b1, REG_CTRL, 32'h1);
    meas_to(16'd51, 16'd0);
    alm(4'b0000);
    cfg(3'h2, TYPE_UPPER_SB, 16'd10, 16'd0, 16'd0);
    cfg(3'h3, TYPE_LOWER_SB, 16'd10, 16'd0, 16'd0);
    meas_to(16'd20, 16'd0);
    xfer(1'b1, REG_CTRL, 32'h1);
    meas_to(16'd20, 16'd0);
    alm(4'b0000);
    meas_to(16'd0, 16'd0);
    meas_to(16'd20, 16'd0);
    alm(4'b0010);
    meas_to(-16'sd20, 16'd0);
    alm(4'b0101);
    xfer(1'b1, REG_CTRL, 32'h1);
    meas_to(-16'sd20, 16'd0);
    alm(4'b0000);
    xfer(1'b1, REG_IRQ_STAT, 32'h1F);
    xfer(1'b1, {3'h2, CH_TYPE}, 32'h0000_010C);
    rdc({3'h2, CH_TYPE}, 32'h0000_0106);
    xfer(1'b0, REG_IRQ_STAT, 32'h0);
    chk(rd & 32'h10, 32'h10);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, REG_IRQ_MASK, 32'h10);
    #1;
    chk({31'h0, irq}, 32'h1);
    xfer(1'b1, REG_IRQ_STAT, 32'h10);
    #1;
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, {3'h1, CH_TYPE}, 32'h0000_010C);
    @(posedge clk_sys);
    lb_set <= 1'b1;
    meas_to(-16'sd20, 16'd0);
    alm(4'b0001);
    @(posedge clk_sys);
    lb_set <= 1'b0;
    meas_to(-16'sd20, 16'd0);
    alm(4'b0000);
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
